// File: bst_if.sv
// Purpose: four-wire test port joining controller and device
// Assumes: controller makes tck; device drives tdo with an enable
// Notes: an undriven tdo line reads high, as with a pull-up
`timescale 1ns/10ps
`default_nettype none

interface bst_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic tdo_line;

    // released line floats high
    assign tdo_line = tdo_oe ? tdo : 1'b1;

    modport dev (
        input tck,
        input tms,
        input tdi,
        output tdo,
        output tdo_oe
    );

    modport host (
        output tck,
        output tms,
        output tdi,
        input tdo_line
    );
endinterface : bst_if

`default_nettype wire

// File: bst_pkg.sv
// Purpose: shared types of the boundary-scan test port
// Assumes: bst_regs.svh holds the numeric constants
// Notes: tap states follow the usual sixteen-state controller
`include "bst_regs.svh"
`default_nettype none

package bst_pkg;

    typedef enum logic [3:0] {
        tap_reset, tap_idle,
        tap_sel_dr, tap_cap_dr, tap_shf_dr, tap_ex1_dr, tap_pau_dr, tap_ex2_dr, tap_upd_dr,
        tap_sel_in, tap_cap_in, tap_shf_in, tap_ex1_in, tap_pau_in, tap_ex2_in, tap_upd_in
    } bst_tap_t;

    // data register currently between tdi and tdo
    typedef enum logic [1:0] {
        dr_bypass, dr_chain, dr_tcr
    } bst_dr_t;

    typedef enum logic [3:0] {
        h_tlr, h_idle, h_sdr, h_sin, h_cap, h_go, h_shf, h_ex1, h_upd
    } bst_host_st_t;

    // next tap state from the sampled tms
    function automatic bst_tap_t bst_tap_next(input bst_tap_t s, input logic tms);
        bst_tap_t n;
        n = s;
        case (s)
            tap_reset: n = tms ? tap_reset : tap_idle;
            tap_idle: n = tms ? tap_sel_dr : tap_idle;
            tap_sel_dr: n = tms ? tap_sel_in : tap_cap_dr;
            tap_cap_dr: n = tms ? tap_ex1_dr : tap_shf_dr;
            tap_shf_dr: n = tms ? tap_ex1_dr : tap_shf_dr;
            tap_ex1_dr: n = tms ? tap_upd_dr : tap_pau_dr;
            tap_pau_dr: n = tms ? tap_ex2_dr : tap_pau_dr;
            tap_ex2_dr: n = tms ? tap_upd_dr : tap_shf_dr;
            tap_upd_dr: n = tms ? tap_sel_dr : tap_idle;
            tap_sel_in: n = tms ? tap_reset : tap_cap_in;
            tap_cap_in: n = tms ? tap_ex1_in : tap_shf_in;
            tap_shf_in: n = tms ? tap_ex1_in : tap_shf_in;
            tap_ex1_in: n = tms ? tap_upd_in : tap_pau_in;
            tap_pau_in: n = tms ? tap_ex2_in : tap_pau_in;
            tap_ex2_in: n = tms ? tap_upd_in : tap_shf_in;
            tap_upd_in: n = tms ? tap_sel_dr : tap_idle;
            default: n = tap_reset;
        endcase
        return n;
    endfunction : bst_tap_next

endpackage : bst_pkg

`default_nettype wire

// File: bst_props.sv
// Purpose: checks on the four test-port wires between the two ends
// Assumes: tck made by the host end; rst_b synchronous to tck
// Notes: keeps its own copy of tap state and active instruction
`timescale 1ns/10ps
`default_nettype none
`include "bst_regs.svh"
module bst_props
    import bst_pkg::*;
(
    // test port and device reset
    input wire logic tck,
    input wire logic rst_b,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // next-state tables, one nibble per state, for tms low and high
    localparam logic [63:0] NXT0 = 64'h1BDDBBA146644311;
    localparam logic [63:0] NXT1 = 64'h2FEFCC0287855920;
    logic [3:0] st;
    logic [7:0] ir_sh;
    logic [7:0] ir_act;
    logic [3:0] rise_q;
    logic byp;
    default clocking cb @(posedge tck); endclocking
    default disable iff (!rst_b);
    // unknown codes fall back to the one-bit bypass path
    assign byp = !(ir_act inside {`BST_INSTR_CHAIN, `BST_INSTR_TCR, `BST_INSTR_RUN_TEST, `BST_INSTR_READ});
    // track tap state and the instruction shifted in
    always_ff @(posedge tck)
    begin
        rise_q <= {tms, tdi, tdo, tdo_oe};
        if (!rst_b || st == 4'h0)
        begin
            ir_act <= 8'hFF;
        end
        else if (st == tap_upd_in)
        begin
            ir_act <= ir_sh;
        end
        ir_sh <= (st == tap_shf_in) ? {tdi, ir_sh[7:1]} : ir_sh;
        st <= !rst_b ? 4'h0 : tms ? NXT1[{st, 2'b00} +: 4] : NXT0[{st, 2'b00} +: 4];
    end
    sequence cap_ir_s;
        st == tap_cap_in ##1 st == tap_shf_in;
    endsequence
    sequence cap_byp_s;
        st == tap_cap_dr && byp ##1 st == tap_shf_dr;
    endsequence
    a_oe_in_shift: assert property (
        st == tap_shf_in || st == tap_shf_dr |-> tdo_oe) else $error("tdo not driven in shift");
    a_oe_entry: assert property (
        $rose(tdo_oe) |-> st == tap_shf_in || st == tap_shf_dr) else $error("tdo driven outside shift");
    a_oe_off_exit: assert property (
        st == tap_ex1_in || st == tap_ex1_dr |-> !tdo_oe) else $error("tdo still driven in exit");
    a_edge_steady: assert property (@(negedge tck)
        {tms, tdi, tdo, tdo_oe} == rise_q) else $error("port changed while tck high");
    a_capture_ir: assert property (
        cap_ir_s |-> tdo ##1 !tdo [*6] ##1 tdo) else $error("wrong captured instruction");
    a_last_shift: assert property (
        st == tap_cap_in |=> (st == tap_shf_in && !tms) [*7] ##1 tms) else $error("tms not raised on last bit");
    a_bypass_zero: assert property (
        cap_byp_s |-> !tdo ##1 (st != tap_shf_dr || tdo == $past(tdi))) else $error("bypass bit wrong");
    a_reset_exit: assert property (
        (st == tap_reset && tms) [*3] |-> ##[1:60] (st == tap_reset && !tms)) else $error("reset never left");
endmodule : bst_props
`default_nettype wire

// File: bst_regs.svh
// Purpose: constants of the boundary-scan test port, both ends
// Assumes: included by bare name; definitions only
// Notes: instruction codes other than capture pattern and bypass are local picks
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

`define BST_INSTR_W 8
`define BST_CAPTURE_PATTERN 8'h81
`define BST_INSTR_BYPASS 8'hFF
`define BST_INSTR_CHAIN 8'h82
`define BST_INSTR_TCR 8'h8E
`define BST_INSTR_RUN_TEST 8'h8A
`define BST_INSTR_READ 8'h86
`define BST_CELLS 18
`define BST_CHAIN_W 36
`define BST_TCR_W 3
`define BST_OP_SIG_COUNT 3'h7
`define BST_SIG_TAP 10
`define BST_COUNT_ONE 18'h00001
`define BST_TLR_CYCLES 3'h5
`define BST_TCK_HALF 4'h4
`define BST_TCK_LAST 4'h7
`define BST_LEN_W 6

`endif

// File: bst_sync2.sv
// Purpose: two-flop synchroniser for one level
// Assumes: d is asynchronous to clk
// Notes: the first flop is read by the second only
`timescale 1ns/10ps
`default_nettype none

module bst_sync2
    import bst_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // level in and out
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic meta;
        logic stable;
    } bst_sync_t;

    bst_sync_t r;
    bst_sync_t next_r;

    // shift the level through two flops
    always_comb
    begin
        next_r.meta = d;
        next_r.stable = r.meta;
        if (!rst_b)
        begin
            next_r = '0;
        end
    end

    // register the state
    always_ff @(posedge clk)
    begin
        r <= next_r;
    end

    assign q = r.stable;
endmodule : bst_sync2

`default_nettype wire

// File: bst_tap_dev.sv
// Purpose: device end of the test port with signature and count-up test
// Assumes: whole device runs on the link's tck; rst_b synchronous to tck
// Notes: rising-edge and falling-edge state are two structs
`timescale 1ns/10ps
`default_nettype none
`include "bst_regs.svh"

module bst_tap_dev
    import bst_pkg::*;
(
    // test port
    bst_if.dev link,
    // reset, synchronous to the link clock
    input wire logic rst_b,
    // functional pins
    input wire logic [`BST_CELLS-1:0] pin_in,
    input wire logic byte1_a_to_b_output_enable,
    input wire logic byte2_b_to_a_output_enable,
    output logic [`BST_CELLS-1:0] pin_out,
    // status
    output logic test_running
);
    // rising-edge state
    typedef struct packed {
        bst_tap_t tap;
        logic [`BST_CELLS-1:0] pin_meta;
        logic [`BST_CELLS-1:0] pin_smp;
        logic [1:0] dir_meta;
        logic [1:0] dir;
        logic [`BST_INSTR_W-1:0] instr_shift;
        logic bypass;
        logic [`BST_TCR_W-1:0] tcr_shift;
        logic [`BST_CELLS-1:0] in_cells;
        logic [`BST_CELLS-1:0] out_cells;
    } bst_rise_t;

    // falling-edge state
    typedef struct packed {
        logic [`BST_INSTR_W-1:0] instr_active;
        logic [`BST_TCR_W-1:0] test_control_register;
        logic [`BST_CELLS-1:0] shadow;
        logic tdo;
        logic tdo_oe;
        logic running;
    } bst_fall_t;

    bst_rise_t r;
    bst_rise_t next_r;
    bst_fall_t f;
    bst_fall_t next_f;
    bst_dr_t dr_sel;
    logic run_now;

    // pick the data register; unknown codes and run-test give bypass, whatever the directions
    function automatic bst_dr_t dr_select(input logic [`BST_INSTR_W-1:0] instr, input logic dir_ok);
        bst_dr_t s;
        s = dr_bypass;
        if (instr == `BST_INSTR_CHAIN)
        begin
            s = dr_chain;
        end
        else if (instr == `BST_INSTR_TCR)
        begin
            s = dr_tcr;
        end
        else if (instr == `BST_INSTR_READ)
        begin
            s = dr_chain;
        end
        else if (instr == `BST_INSTR_RUN_TEST && !dir_ok)
        begin
            s = dr_bypass;
        end
        else
        begin
            s = dr_bypass;
        end
        return s;
    endfunction : dr_select

    // one signature step: shift with feedback, then fold in the pins
    function automatic logic [`BST_CELLS-1:0] sig_step(input logic [`BST_CELLS-1:0] s,
                                                       input logic [`BST_CELLS-1:0] d);
        logic fb;
        fb = s[`BST_CELLS-1] ^ s[`BST_SIG_TAP];
        return {s[`BST_CELLS-2:0], fb} ^ d;
    endfunction : sig_step

    // both bytes must agree on one flow direction
    assign dr_sel = dr_select(f.instr_active, r.dir[0] == r.dir[1]);

    // test runs only in idle with run-test active, opcode 111, directions agreeing
    assign run_now = (r.tap == tap_idle)
        && (f.instr_active == `BST_INSTR_RUN_TEST)
        && (f.test_control_register == `BST_OP_SIG_COUNT)
        && (r.dir[0] == r.dir[1]);

    // rising edge: sample pins and tms, capture, shift, run the test
    always_comb
    begin
        next_r = r;
        next_r.pin_meta = pin_in;
        next_r.pin_smp = r.pin_meta;
        next_r.dir_meta = {byte2_b_to_a_output_enable, byte1_a_to_b_output_enable};
        next_r.dir = r.dir_meta;
        next_r.tap = bst_tap_next(r.tap, link.tms);
        case (r.tap)
            tap_cap_in:
            begin
                next_r.instr_shift = `BST_CAPTURE_PATTERN;
            end
            tap_shf_in:
            begin
                next_r.instr_shift = {link.tdi, r.instr_shift[`BST_INSTR_W-1:1]};
            end
            tap_cap_dr:
            begin
                if (dr_sel == dr_bypass)
                begin
                    next_r.bypass = 1'b0;
                end
                else if (dr_sel == dr_chain)
                begin
                    // read-back code keeps the signature so it can be unloaded
                    if (f.instr_active != `BST_INSTR_READ)
                    begin
                        next_r.in_cells = r.pin_smp;
                    end
                end
                else
                begin
                    next_r.tcr_shift = f.test_control_register; // value unchanged by capture
                end
            end
            tap_shf_dr:
            begin
                if (dr_sel == dr_bypass)
                begin
                    next_r.bypass = link.tdi;
                end
                else if (dr_sel == dr_chain)
                begin
                    {next_r.out_cells, next_r.in_cells} = {link.tdi, r.out_cells, r.in_cells[`BST_CELLS-1:1]};
                end
                else
                begin
                    next_r.tcr_shift = {link.tdi, r.tcr_shift[`BST_TCR_W-1:1]};
                end
            end
            tap_idle:
            begin
                if (run_now)
                begin
                    next_r.in_cells = sig_step(r.in_cells, r.pin_smp);
                    next_r.out_cells = r.out_cells + `BST_COUNT_ONE;
                end
            end
            default:
            begin
                next_r.tap = next_r.tap;
            end
        endcase
        if (!rst_b)
        begin
            next_r = '0;
            next_r.tap = tap_reset;
        end
    end

    // register rising-edge state
    always_ff @(posedge link.tck)
    begin
        r <= next_r;
    end

    // falling edge: drive tdo, update instruction and control, drive pins
    always_comb
    begin
        next_f = f;
        next_f.running = run_now;
        next_f.tdo_oe = (r.tap == tap_shf_in) || (r.tap == tap_shf_dr);
        case (r.tap)
            tap_shf_in:
            begin
                next_f.tdo = r.instr_shift[0];
            end
            tap_shf_dr:
            begin
                if (dr_sel == dr_bypass)
                begin
                    next_f.tdo = r.bypass;
                end
                else if (dr_sel == dr_chain)
                begin
                    next_f.tdo = r.in_cells[0];
                end
                else
                begin
                    next_f.tdo = r.tcr_shift[0];
                end
            end
            tap_upd_in:
            begin
                next_f.instr_active = r.instr_shift;
            end
            tap_upd_dr:
            begin
                if (dr_sel == dr_tcr)
                begin
                    next_f.test_control_register = r.tcr_shift;
                end
                else if (dr_sel == dr_chain)
                begin
                    next_f.shadow = r.out_cells;
                end
                else
                begin
                    next_f.shadow = f.shadow;
                end
            end
            tap_reset:
            begin
                next_f.instr_active = `BST_INSTR_BYPASS;
            end
            tap_idle:
            begin
                if (run_now)
                begin
                    next_f.shadow = r.out_cells;
                end
            end
            default:
            begin
                next_f.tdo = f.tdo;
            end
        endcase
        if (!rst_b)
        begin
            next_f = '0;
            next_f.instr_active = `BST_INSTR_BYPASS;
        end
    end

    // register falling-edge state
    always_ff @(negedge link.tck)
    begin
        f <= next_f;
    end

    // outputs straight from falling-edge flops
    assign link.tdo = f.tdo;
    assign link.tdo_oe = f.tdo_oe;
    assign pin_out = f.shadow;
    assign test_running = f.running;
endmodule : bst_tap_dev

`default_nettype wire

// File: bst_tap_host.sv
// Purpose: controller end; makes tck and walks the tap through scans
// Assumes: clk at 20 MHz; tck is clk divided by eight
// Notes: tms and tdi change with tck falling; tdo is taken at tck rising
`timescale 1ns/10ps
`default_nettype none
`include "bst_regs.svh"

module bst_tap_host
    import bst_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // test port
    bst_if.host link,
    // scan request
    input wire logic cmd_valid,
    input wire logic cmd_instr,
    input wire logic [`BST_LEN_W-1:0] cmd_len,
    input wire logic [`BST_CHAIN_W-1:0] cmd_data,
    output logic cmd_ready,
    // scan result
    output logic rsp_valid,
    output logic [`BST_CHAIN_W-1:0] rsp_data
);
    typedef struct packed {
        bst_host_st_t st;
        logic [3:0] div;
        logic [2:0] tlr_cnt;
        logic [`BST_LEN_W-1:0] idx;
        logic [`BST_LEN_W-1:0] len;
        logic instr;
        logic pend;
        logic [`BST_CHAIN_W-1:0] data;
        logic [`BST_CHAIN_W-1:0] rsp;
        logic rsp_valid;
        logic ready;
        logic tck;
        logic tms;
        logic tdi;
    } bst_host_reg_t;

    bst_host_reg_t r;
    bst_host_reg_t next_r;
    logic tdo_s;
    logic rise_evt;
    logic fall_evt;

    // tdo comes from the far side: resynchronise first
    bst_sync2 u_tdo_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(link.tdo_line),
        .q(tdo_s)
    );

    assign rise_evt = (r.div == `BST_TCK_HALF - 4'h1);
    assign fall_evt = (r.div == `BST_TCK_LAST);

    // divider, request intake, tap walk
    always_comb
    begin
        next_r = r;
        next_r.rsp_valid = 1'b0;
        next_r.div = fall_evt ? 4'h0 : r.div + 4'h1;
        if (r.ready && cmd_valid)
        begin
            next_r.ready = 1'b0;
            next_r.pend = 1'b1;
            next_r.instr = cmd_instr;
            next_r.len = cmd_len;
            next_r.data = cmd_data;
            next_r.rsp = '0;
        end
        if (rise_evt)
        begin
            next_r.tck = 1'b1;
            if (r.st == h_shf)
            begin
                next_r.rsp[r.idx] = tdo_s;
            end
        end
        if (fall_evt)
        begin
            next_r.tck = 1'b0;
            case (r.st)
                h_tlr:
                begin
                    next_r.tlr_cnt = r.tlr_cnt + 3'h1;
                    if (r.tlr_cnt == `BST_TLR_CYCLES - 3'h1)
                    begin
                        next_r.st = h_idle;
                        next_r.ready = 1'b1;
                    end
                end
                h_idle: next_r.st = r.pend ? h_sdr : h_idle;
                h_sdr: next_r.st = r.instr ? h_sin : h_cap;
                h_sin: next_r.st = h_cap;
                h_cap: next_r.st = h_go;
                h_go:
                begin
                    next_r.st = h_shf;
                    next_r.idx = '0;
                end
                h_shf:
                begin
                    next_r.idx = r.idx + 6'h01;
                    if (r.idx == r.len - 6'h01)
                    begin
                        next_r.st = h_ex1;
                    end
                end
                h_ex1: next_r.st = h_upd;
                h_upd:
                begin
                    next_r.st = h_idle;
                    next_r.pend = 1'b0;
                    next_r.ready = 1'b1;
                    next_r.rsp_valid = 1'b1;
                end
                default: next_r.st = h_tlr;
            endcase
            // tms for the coming rise, set with tck falling
            case (next_r.st)
                h_tlr, h_sdr, h_sin, h_ex1: next_r.tms = 1'b1;
                h_shf: next_r.tms = (next_r.idx == r.len - 6'h01);
                default: next_r.tms = 1'b0;
            endcase
            next_r.tdi = (next_r.st == h_shf) ? r.data[next_r.idx] : 1'b1;
        end
        if (!rst_b)
        begin
            next_r = '0;
            next_r.st = h_tlr;
            next_r.tms = 1'b1;
            next_r.tdi = 1'b1;
        end
    end

    // register the state
    always_ff @(posedge clk)
    begin
        r <= next_r;
    end

    assign link.tck = r.tck;
    assign link.tms = r.tms;
    assign link.tdi = r.tdi;
    assign cmd_ready = r.ready;
    assign rsp_valid = r.rsp_valid;
    assign rsp_data = r.rsp;
endmodule : bst_tap_host

`default_nettype wire

// File: testbench.sv
// Purpose: runs both ends of the test port against each other
// Assumes: host makes tck from clk; device reset released on a tck fall
// Notes: counts are read on the device's pins while it runs
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk, rst_b, dev_rst_b, en_ab, en_ba, cmd_valid, cmd_instr, cmd_ready, rsp_valid, test_running;
    logic [5:0] cmd_len;
    logic [35:0] cmd_data, rsp_data;
    logic [17:0] pin_in, pin_out;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    bst_if link();
    bst_tap_host bst_tap_host_i (.clk(clk), .rst_b(rst_b), .link(link), .cmd_valid(cmd_valid),
        .cmd_instr(cmd_instr), .cmd_len(cmd_len), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    bst_tap_dev bst_tap_dev_i (.link(link), .rst_b(dev_rst_b), .pin_in(pin_in),
        .byte1_a_to_b_output_enable(en_ab), .byte2_b_to_a_output_enable(en_ba),
        .pin_out(pin_out), .test_running(test_running));
    bst_props bst_props_i (.tck(link.tck), .rst_b(dev_rst_b), .tms(link.tms), .tdi(link.tdi),
        .tdo(link.tdo), .tdo_oe(link.tdo_oe));
    // 20 MHz system clock
    always #25 clk = ~clk;
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one scan request, held until taken, then wait for the answer
    task automatic scan(input logic ins, input logic [5:0] len, input logic [35:0] d, output logic [35:0] r);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_instr = ins;
        cmd_len = len;
        cmd_data = d;
        @(posedge clk);
        while (cmd_ready !== 1'b1)
            @(posedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        @(posedge clk);
        while (rsp_valid !== 1'b1)
            @(posedge clk);
        r = rsp_data;
    endtask : scan
    task automatic load_instr(input logic [7:0] code);
        logic [35:0] r;
        scan(1'b1, 6'h08, {28'h0, code}, r);
        chk("captured instruction", 36'h81, r);
    endtask : load_instr
    task automatic test_bypass();
        logic [35:0] r;
        logic [7:0] code [2] = '{8'hFF, 8'h00};
        foreach (code[i])
        begin
            load_instr(code[i]);
            scan(1'b0, 6'h04, 36'hB, r);
            chk("bypass data", 36'h6, r);
        end
    endtask : test_bypass
    task automatic test_control();
        logic [35:0] r;
        load_instr(8'h8E);
        scan(1'b0, 6'h03, 36'h7, r);
        chk("control after reset", 36'h0, r);
        scan(1'b0, 6'h03, 36'h7, r);
        chk("control held", 36'h7, r);
    endtask : test_control
    task automatic wait_run(input logic exp);
        for (int n = 0; n < 60 && test_running !== exp; n++)
            @(posedge link.tck);
        chk("running", {35'h0, exp}, {35'h0, test_running});
    endtask : wait_run
    task automatic test_count();
        logic [35:0] r;
        logic [17:0] v [4];
        logic [17:0] sig;
        logic [17:0] steps;
        load_instr(8'h82);
        scan(1'b0, 6'h24, 36'hFFFF40000, r);
        chk("captured pins", {18'h0, pin_in}, {18'h0, r[17:0]});
        load_instr(8'h8A);
        wait_run(1'b1);
        foreach (v[i])
        begin
            @(posedge link.tck);
            v[i] = pin_out;
        end
        for (int i = 1; i < 4; i++)
            chk("count step", {18'h0, v[i-1] + 18'h1}, {18'h0, v[i]});
        load_instr(8'h82);
        wait_run(1'b0);
        v[0] = pin_out;
        repeat (4) @(posedge link.tck);
        chk("count held", {18'h0, v[0]}, {18'h0, pin_out});
        load_instr(8'h86);
        scan(1'b0, 6'h24, 36'h48D140000, r);
        chk("shadow update", 36'h12345, {18'h0, pin_out});
        // one more count on the rise that left idle; the signature stepped as often
        chk("final count", {18'h0, v[0] + 18'h1}, {18'h0, r[35:18]});
        steps = r[35:18] - 18'h3FFFD;
        sig = 18'h0;
        for (int i = 0; i < steps; i++)
            sig = {sig[16:0], sig[17] ^ sig[10]} ^ pin_in;
        chk("signature", {18'h0, sig}, {18'h0, r[17:0]});
    endtask : test_count
    task automatic test_direction();
        @(negedge clk);
        en_ba = 1'b0;
        load_instr(8'h8A);
        repeat (20) @(posedge link.tck);
        chk("mixed direction run", 36'h0, {35'h0, test_running});
        chk("mixed direction pins", 36'h12345, {18'h0, pin_out});
        @(negedge clk);
        en_ba = 1'b1;
        wait_run(1'b1);
    endtask : test_direction
    // reset both ends, then the scenarios
    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        dev_rst_b = 1'b0;
        cmd_valid = 1'b0;
        cmd_instr = 1'b0;
        cmd_len = 6'h00;
        cmd_data = 36'h0;
        pin_in = 18'h2A5C3;
        en_ab = 1'b1;
        en_ba = 1'b1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge link.tck);
        dev_rst_b <= 1'b1;
        test_bypass();
        test_control();
        test_count();
        test_direction();
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
